// ===== verilog/can_mode_ctrl.sv
/*
 Mode control and data path of the high-speed CAN transceiver: off, normal,
 receive-only and wake-capable modes, transmitter enabling delay, wake latch.
 Assumes mode requests come from the core SPI decoder as a one-cycle strobe,
 and that the bus comparator output is synchronous to ref_clk.
*/
// Contract
// - Power-up mode is off, everything inactive
// - Off mode selectable in every system mode
// - Off mode ignores bus wake activity
// - Normal mode only from normal system mode
// - Normal mode forwards transmit input to driver
// - Early low input waits for next recessive
// - Receiving modes report bus state on output
// - Distinct receive-only mode setting exists
// - Wake-capable mode detects bus wake pattern
// - Data path supports rates up to 5Mbaud
// - Receive-only: driver off, receiver on, normal/stop
// - Wake pulls receive output low until change
// - Wake-capable encodes 01, kept after wake
`timescale 1ns/1ps
module can_mode_ctrl
	import can_mode_pkg::*;
#(
	parameter int EN_DELAY_CYC = TX_EN_DELAY_CYC,
	parameter int WAKE_T1      = WAKE_T1_CYC,
	parameter int WAKE_T2      = WAKE_T2_CYC
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Mode request from the SPI decoder
	input  wire logic       mode_wr,
	input  wire logic [1:0] mode_req,
	input  wire logic [2:0] sys_mode,
	// Protocol controller pins
	input  wire logic       tx_data_in,
	output logic            rx_data_out,
	// Bus side
	input  wire logic       bus_dominant,
	output logic            drv_dominant,
	output logic            drv_enable,
	output logic            rx_enable,
	// Status
	output logic [1:0]      trx_mode,
	output logic            tx_ready,
	output logic            bus_wake
);
	typedef struct packed {
		logic [1:0]       mode;
		logic [CNT_W-1:0] en_cnt;
		logic             tx_armed;
		logic             woken;
		logic             rx_q;
		logic             drv_q;
		logic             drv_en_q;
		logic             rx_en_q;
		logic             ready_q;
		logic             wake_q;
	} ctrl_t;

	ctrl_t cur, next_cur;
	logic  wake_pulse;
	logic  mode_ok;

	// Whether a requested mode is legal in the present system mode
	function automatic logic mode_allowed(input logic [1:0] m, input logic [2:0] s);
		case (m)
			TRX_OFF:     mode_allowed = 1'b1;
			TRX_NORMAL:  mode_allowed = (s == SYS_NORMAL);
			TRX_RX_ONLY: mode_allowed = (s == SYS_NORMAL) || (s == SYS_STOP);
			TRX_WAKE:    mode_allowed = (s != SYS_FAILSAFE);
			default:     mode_allowed = 1'b0;
		endcase
	endfunction

	assign mode_ok = mode_allowed(mode_req, sys_mode);

	// Detector is idle outside wake-capable mode and once woken
	can_wake_detect #(
		.T1_CYC (WAKE_T1),
		.T2_CYC (WAKE_T2)
	) u_wake (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.armed        ((cur.mode == TRX_WAKE) && !cur.woken),
		.bus_dominant (bus_dominant),
		.wake_pulse   (wake_pulse)
	);

	always_comb begin
		next_cur = cur;
		// Illegal requests are dropped, the current mode stays
		if (mode_wr && mode_ok && (mode_req != cur.mode)) begin
			next_cur.mode = mode_req;
			next_cur.en_cnt = CNT_ZERO;
			next_cur.tx_armed = 1'b0;
			next_cur.woken = 1'b0;
		end else begin
			if (wake_pulse)
				next_cur.woken = 1'b1;
			if ((cur.mode == TRX_NORMAL) && (cur.en_cnt < CNT_W'(EN_DELAY_CYC)))
				next_cur.en_cnt = cur.en_cnt + CNT_ONE;
			// Arm only on a high input after the delay; an early low is never sent
			if ((cur.mode == TRX_NORMAL) && (cur.en_cnt >= CNT_W'(EN_DELAY_CYC)) && tx_data_in)
				next_cur.tx_armed = 1'b1;
		end
		// Single registered stage each way keeps loop delay to two cycles at 5 Mbaud
		case (cur.mode)
			TRX_NORMAL: begin
				next_cur.drv_en_q = 1'b1;
				next_cur.rx_en_q = 1'b1;
				next_cur.drv_q = cur.tx_armed && !tx_data_in;
				next_cur.rx_q = !bus_dominant;
			end
			TRX_RX_ONLY: begin
				next_cur.drv_en_q = 1'b0;
				next_cur.rx_en_q = 1'b1;
				next_cur.drv_q = 1'b0;
				next_cur.rx_q = !bus_dominant;
			end
			TRX_WAKE: begin
				next_cur.drv_en_q = 1'b0;
				next_cur.rx_en_q = 1'b0;
				next_cur.drv_q = 1'b0;
				next_cur.rx_q = !(cur.woken || wake_pulse);
			end
			default: begin
				next_cur.drv_en_q = 1'b0;
				next_cur.rx_en_q = 1'b0;
				next_cur.drv_q = 1'b0;
				next_cur.rx_q = 1'b1;
			end
		endcase
		next_cur.ready_q = (cur.mode == TRX_NORMAL) && cur.tx_armed;
		// Follows the latch itself so a mode change clears it in the same edge
		next_cur.wake_q = next_cur.woken;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '{mode: TRX_OFF, en_cnt: CNT_ZERO, tx_armed: 1'b0, woken: 1'b0,
				rx_q: 1'b1, drv_q: 1'b0, drv_en_q: 1'b0, rx_en_q: 1'b0,
				ready_q: 1'b0, wake_q: 1'b0};
		end else begin
			cur <= next_cur;
		end
	end

	assign rx_data_out  = cur.rx_q;
	assign drv_dominant = cur.drv_q;
	assign drv_enable   = cur.drv_en_q;
	assign rx_enable    = cur.rx_en_q;
	assign trx_mode     = cur.mode;
	assign tx_ready     = cur.ready_q;
	assign bus_wake     = cur.wake_q;
endmodule

// ===== common/can_mode_pkg.sv
/*
 Package for the CAN transceiver mode control block: mode and system-mode
 encodings, timing figures and the cycle counts derived from them.
 Assumes a 100 MHz core clock.
*/
package can_mode_pkg;
	localparam int CLK_MHZ = 100;

	// Transceiver mode field encodings
	localparam logic [1:0] TRX_OFF     = 2'h0;
	localparam logic [1:0] TRX_WAKE    = 2'h1;
	localparam logic [1:0] TRX_RX_ONLY = 2'h2;
	localparam logic [1:0] TRX_NORMAL  = 2'h3;

	// System operating modes of the chip core
	localparam logic [2:0] SYS_NORMAL  = 3'h0;
	localparam logic [2:0] SYS_STOP    = 3'h1;
	localparam logic [2:0] SYS_SLEEP   = 3'h2;
	localparam logic [2:0] SYS_RESTART = 3'h3;
	localparam logic [2:0] SYS_FAILSAFE = 3'h4;

	// Transmitter enabling delay, in ns
	localparam int TX_EN_DELAY_NS  = 20000;
	localparam int TX_EN_DELAY_CYC = (TX_EN_DELAY_NS * CLK_MHZ + 999) / 1000;

	// Wake pattern phase bounds, in ns (least rounds up, longest rounds down)
	localparam int WAKE_T1_NS  = 500;
	localparam int WAKE_T2_NS  = 1000000;
	localparam int WAKE_T1_CYC = (WAKE_T1_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_T2_CYC = (WAKE_T2_NS * CLK_MHZ) / 1000;

	localparam int CNT_W = 20;
	localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
	localparam logic [CNT_W-1:0] CNT_ONE  = 20'h00001;
endpackage

// ===== verilog/can_wake_detect.sv
/*
 Bus wake-up pattern detector: dominant, recessive, dominant phases, each
 longer than the short bound and shorter than the long bound.
 Assumes bus_dominant is synchronous to ref_clk.
*/
`timescale 1ns/1ps
module can_wake_detect
	import can_mode_pkg::*;
#(
	parameter int T1_CYC = WAKE_T1_CYC,
	parameter int T2_CYC = WAKE_T2_CYC
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Control
	input  wire logic armed,
	input  wire logic bus_dominant,
	// Result
	output logic      wake_pulse
);
	typedef enum logic [2:0] {W_IDLE, W_DOM1, W_REC, W_DOM2, W_HIT} wstate_t;
	typedef struct packed {
		wstate_t          st;
		logic [CNT_W-1:0] cnt;
		logic             pulse;
	} wdet_t;

	wdet_t cur, next_cur;

	function automatic logic in_window(input logic [CNT_W-1:0] c);
		in_window = (c >= CNT_W'(T1_CYC)) && (c < CNT_W'(T2_CYC));
	endfunction

	always_comb begin
		next_cur = cur;
		next_cur.pulse = 1'b0;
		if (cur.cnt != {CNT_W{1'b1}})
			next_cur.cnt = cur.cnt + CNT_ONE;
		case (cur.st)
			W_IDLE: begin
				next_cur.cnt = CNT_ZERO;
				if (bus_dominant)
					next_cur.st = W_DOM1;
			end
			W_DOM1: begin
				if (!bus_dominant) begin
					next_cur.st = in_window(cur.cnt) ? W_REC : W_IDLE;
					next_cur.cnt = CNT_ZERO;
				end
			end
			W_REC: begin
				if (bus_dominant) begin
					next_cur.st = in_window(cur.cnt) ? W_DOM2 : W_DOM1;
					next_cur.cnt = CNT_ZERO;
				end else if (cur.cnt >= CNT_W'(T2_CYC)) begin
					next_cur.st = W_IDLE;
				end
			end
			W_DOM2: begin
				// Long dominant phases are clamps, not wake patterns
				if (!bus_dominant) begin
					next_cur.st = in_window(cur.cnt) ? W_HIT : W_IDLE;
					next_cur.cnt = CNT_ZERO;
				end
			end
			W_HIT: begin
				next_cur.pulse = 1'b1;
				next_cur.st = W_IDLE;
			end
			default: next_cur.st = W_IDLE;
		endcase
		if (!armed) begin
			next_cur.st = W_IDLE;
			next_cur.pulse = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			cur <= '{st: W_IDLE, cnt: CNT_ZERO, pulse: 1'b0};
		else
			cur <= next_cur;
	end

	assign wake_pulse = cur.pulse;
endmodule

// ===== tb/can_mode_ctrl_properties.sv
/*
 Port checker for can_mode_ctrl.
 Assumes it is bound to every instance of can_mode_ctrl.
*/
`timescale 1ns/1ps
module can_mode_ctrl_props
	import can_mode_pkg::*;
(
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_n,
	// Requests and pins
	input wire logic       mode_wr,
	input wire logic [1:0] mode_req,
	input wire logic [2:0] sys_mode,
	input wire logic       tx_data_in,
	input wire logic       bus_dominant,
	// Outputs
	input wire logic       rx_data_out,
	input wire logic       drv_dominant,
	input wire logic       drv_enable,
	input wire logic       rx_enable,
	input wire logic [1:0] trx_mode,
	input wire logic       tx_ready,
	input wire logic       bus_wake
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Outputs lag the mode field by a cycle, hence two samples
	off_quiet_a: assert property ((trx_mode == TRX_OFF)[*2] |-> rx_data_out && !drv_enable
		&& !drv_dominant && !rx_enable) else $error("off mode outputs active");
	off_any_a: assert property (mode_wr && mode_req == TRX_OFF |=> trx_mode == TRX_OFF)
		else $error("off mode request lost");
	normal_gate_a: assert property (mode_wr && sys_mode != SYS_NORMAL
		&& trx_mode != TRX_NORMAL |=> trx_mode != TRX_NORMAL) else $error("normal taken");
	wake_code_a: assert property (mode_wr && mode_req == 2'h1
		&& sys_mode != SYS_FAILSAFE |=> trx_mode == 2'h1) else $error("wake code wrong");
	wake_off_a: assert property ($rose(bus_wake) |-> trx_mode == TRX_WAKE)
		else $error("wake outside wake mode");
	wake_hold_a: assert property (bus_wake && trx_mode == TRX_WAKE && !mode_wr
		|=> bus_wake && !rx_data_out) else $error("wake not held");
	tx_path_a: assert property (drv_dominant |-> drv_enable
		&& $past(trx_mode) == TRX_NORMAL && !$past(tx_data_in)) else $error("bad dominant");
	tx_early_a: assert property ((!tx_ready)[*2] |-> !drv_dominant)
		else $error("dominant before arming");
	rx_follow_a: assert property ((trx_mode[1])[*2] |=> rx_data_out == !$past(bus_dominant))
		else $error("receive output wrong");
	rx_only_a: assert property ((trx_mode == TRX_RX_ONLY)[*2] |-> !drv_enable && rx_enable)
		else $error("receive only drives");
	cover property (tx_ready && drv_dominant);
	cover property ($rose(bus_wake));
	cover property ((trx_mode == TRX_RX_ONLY)[*3]);
endmodule

bind can_mode_ctrl can_mode_ctrl_props u_props (.*);

// ===== tb/can_far_side.sv
/*
 Far side: the bus, as a dominant-wins OR of our driver and one other node.
 Assumes the testbench drives other_dom for the other node.
*/
`timescale 1ns/1ps
module can_far_side (
	// Our driver
	input  wire logic drv_dominant,
	input  wire logic drv_enable,
	// Other node and comparator
	input  wire logic other_dom,
	output logic      bus_dominant
);
	// A disabled driver leaves the bus to the other node
	assign bus_dominant = (drv_enable & drv_dominant) | other_dom;
endmodule

// ===== tb/can_mode_ctrl_tb.sv
/*
 Testbench for can_mode_ctrl with short enabling and wake counts.
 Assumes the far-side bus model and the bound checker.
*/
`timescale 1ns/1ps
module can_mode_ctrl_tb;
	import can_mode_pkg::*;
	logic       ref_clk, rst_n, mode_wr, tx_data_in, other_dom, bus_dominant;
	logic [1:0] mode_req, trx_mode;
	logic [2:0] sys_mode;
	logic       rx_data_out, drv_dominant, drv_enable, rx_enable, tx_ready, bus_wake;
	int         fails = 0, cmp_count = 0, cyc = 0;
	can_mode_ctrl #(.EN_DELAY_CYC(8), .WAKE_T1(4), .WAKE_T2(20)) DUT (.*);
	can_far_side bus (.*);
	task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic set_mode(input logic [1:0] m);
		mode_wr = 1'b1;
		mode_req = m;
		cyc_n(1);
		mode_wr = 1'b0;
		cyc_n(2);
	endtask
	// Dominant, recessive, dominant, recessive: 8 cycles each, inside 4..20
	task automatic pattern();
		for (int i = 0; i < 4; i++) begin
			other_dom = !i[0];
			cyc_n(8);
		end
		cyc_n(4);
	endtask
	task automatic t_rx_only();
		sys_mode = SYS_STOP;
		set_mode(TRX_NORMAL);
		chk("mode", TRX_OFF, trx_mode);
		set_mode(TRX_RX_ONLY);
		chk("mode", TRX_RX_ONLY, trx_mode);
		other_dom = 1'b1;
		tx_data_in = 1'b0;
		cyc_n(2);
		chk("rx", 2'h0, rx_data_out);
		chk("drv", 2'h0, {drv_enable, drv_dominant});
		set_mode(TRX_OFF);
		chk("rx", 2'h1, rx_data_out);
		chk("drv", 2'h0, {drv_enable, drv_dominant});
		other_dom = 1'b0;
		tx_data_in = 1'b1;
		$display("receive only test done");
	endtask
	task automatic t_normal();
		sys_mode = SYS_NORMAL;
		tx_data_in = 1'b0;
		set_mode(TRX_NORMAL);
		cyc_n(12);
		chk("drv", 2'h2, {drv_enable, drv_dominant});
		tx_data_in = 1'b1;
		cyc_n(3);
		chk("ready", 2'h1, tx_ready);
		for (int i = 0; i < 6; i++) begin
			tx_data_in = i[0];
			cyc_n(1);
			chk("drv", {1'b1, ~i[0]}, {drv_enable, drv_dominant});
			chk("rx", {1'b0, ~i[0]}, rx_data_out);
		end
		tx_data_in = 1'b1;
		set_mode(TRX_OFF);
		$display("normal test done");
	endtask
	task automatic t_wake();
		pattern();
		chk("wake", 2'h0, bus_wake);
		set_mode(TRX_WAKE);
		pattern();
		chk("wake", 2'h1, bus_wake);
		chk("rx", 2'h0, rx_data_out);
		chk("mode", TRX_WAKE, trx_mode);
		set_mode(TRX_OFF);
		chk("wake", 2'h0, bus_wake);
		$display("wake test done");
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// The whole run needs about 120 cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		{rst_n, mode_wr, other_dom} = 3'h0;
		tx_data_in = 1'b1;
		mode_req = TRX_OFF;
		sys_mode = SYS_NORMAL;
		cyc_n(3);
		rst_n = 1'b1;
		cyc_n(1);
		chk("mode", TRX_OFF, trx_mode);
		chk("idle", 2'h1, {rx_enable | drv_enable | bus_wake | tx_ready, rx_data_out});
		t_rx_only();
		t_normal();
		t_wake();
		end_sim();
	end
endmodule
